/* File: tcc_defs.svh */
// register map, field positions, reset values and timing counts of the timer control block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ---------------------------------------------------------------
// register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define TCC_IDX_MAIN_CONTROL   8'h00
`define TCC_IDX_READ_SYNC_REQ  8'h02
`define TCC_IDX_SECOND_CONTROL_CLEAR    8'h04
`define TCC_IDX_SECOND_CONTROL_SET      8'h05
`define TCC_IDX_SYNC_STATUS    8'h0F
`define TCC_IDX_COUNT          8'h10
`define TCC_IDX_PERIOD         8'h14
`define TCC_IDX_COMPARE0       8'h18
`define TCC_IDX_COMPARE1       8'h1C

// ---------------------------------------------------------------
// main_control fields
// ---------------------------------------------------------------
`define TCC_MC_SOFTWARE_RESET           0
`define TCC_MC_ENABLE          1
`define TCC_MC_WIDTH_LO        2
`define TCC_MC_WAVE_LO         5
`define TCC_MC_PRESC_LO        8
`define TCC_MC_STBY            11
`define TCC_MC_RSYNC_LO        12

// ---------------------------------------------------------------
// read_sync_request and second_control fields
// ---------------------------------------------------------------
`define TCC_RR_REQ             15
`define TCC_RR_CONT            14
`define TCC_CB_DIR             0
`define TCC_CB_SINGLE          2
`define TCC_CB_CMD_LO          6

// ---------------------------------------------------------------
// sync status fields
// ---------------------------------------------------------------
`define TCC_SS_SOFTWARE_RESET           0
`define TCC_SS_ENABLE          1
`define TCC_SS_READ            2
`define TCC_SS_ANY             7

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define TCC_RST_WORD           32'h0000_0000
`define TCC_SYNC_CYCLES        3'h3
`define TCC_SYNC_LAST          (`TCC_SYNC_CYCLES - 3'h1)
`define TCC_MAX16              32'h0000_FFFF
`define TCC_MAX32              32'hFFFF_FFFF
`define TCC_MAX8               32'h0000_00FF

`endif

/* File: tcc_pkg.sv */
// types of the timer control block
package tcc_pkg;

  typedef enum logic [1:0] {
    TCC_RS_GENERIC  = 2'b00,
    TCC_RS_PRESCALE = 2'b01,
    TCC_RS_RESYNC   = 2'b10,
    TCC_RS_RSVD     = 2'b11
  } tcc_rsync_e;

  typedef enum logic [1:0] {
    TCC_WM_NORMAL_FREQUENCY_MODE = 2'b00,
    TCC_WM_MATCH_FREQUENCY_MODE = 2'b01,
    TCC_WM_NORMAL_PWM_MODE = 2'b10,
    TCC_WM_MATCH_PWM_MODE = 2'b11
  } tcc_wave_e;

  typedef enum logic [1:0] {
    TCC_W16  = 2'b00,
    TCC_W8   = 2'b01,
    TCC_W32  = 2'b10,
    TCC_WRSV = 2'b11
  } tcc_width_e;

  typedef enum logic [1:0] {
    TCC_CMD_NONE    = 2'b00,
    TCC_CMD_RETRIG  = 2'b01,
    TCC_CMD_STOP    = 2'b10,
    TCC_CMD_RSVD    = 2'b11
  } tcc_cmd_e;

  typedef struct packed {
    tcc_rsync_e  reloadSync;
    logic        standbyRun;
    logic [2:0]  prescSel;
    tcc_wave_e   waveMode;
    tcc_width_e  widthSel;
    logic        enable;
    logic        swReset;
    logic [2:0]  ctrlCnt;
    logic        enBusy;
    logic        swBusy;
    logic        enActive;
    logic        contRead;
    logic [4:0]  readAddr;
    logic        rdBusy;
    logic [2:0]  rdCnt;
    logic [31:0] snapshot;
    tcc_cmd_e    cmd;
    logic        singleRun;
    logic        countDown;
    logic        running;
    logic        reloadPend;
    logic [9:0]  prescCnt;
    logic [31:0] count;
    logic [7:0]  period;
    logic [31:0] cmp0;
    logic [31:0] cmp1;
    logic [1:0]  wave;
    logic        stbyMeta;
    logic        stbySync;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tcc_state_s;

endpackage : tcc_pkg

/* File: tcc_top.sv */
// timer/counter control registers, prescaler, counter and waveform logic
`include "tcc_defs.svh"

module tcc_top
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // system
  input  wire logic        standbyIn,
  // timer outputs
  output logic [1:0]       waveOut,
  output logic             countRunning
);

  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  tcc_state_s  s_q;
  tcc_state_s  s_d;

  logic [7:0]  regIdx;
  logic        mapped;
  logic        wrAcc;
  logic        halt;
  logic        tick;
  logic [9:0]  prescTerm;
  logic [31:0] widthMax;
  logic [31:0] topVal;
  logic [31:0] readSrc;
  logic        readOk;
  logic        isMatchMode;
  logic        isPwm;
  logic [15:0] mainCtrlRd;
  logic [7:0]  ctrlbRd;
  logic [7:0]  statusRd;

  assign regIdx = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                  (regIdx == `TCC_IDX_MAIN_CONTROL || regIdx == `TCC_IDX_READ_SYNC_REQ ||
                   regIdx == `TCC_IDX_SECOND_CONTROL_CLEAR || regIdx == `TCC_IDX_SECOND_CONTROL_SET ||
                   regIdx == `TCC_IDX_SYNC_STATUS || regIdx == `TCC_IDX_COUNT ||
                   regIdx == `TCC_IDX_PERIOD || regIdx == `TCC_IDX_COMPARE0 ||
                   regIdx == `TCC_IDX_COMPARE1);
  assign wrAcc  = psel && penable && s_q.pready && pwrite && mapped;

  // ---------------------------------------------------------------
  // prescaler and timing
  // ---------------------------------------------------------------
  // standby halt
  assign halt = s_q.stbySync && !s_q.standbyRun;

  always_comb begin
    unique case (s_q.prescSel)
      3'h0: prescTerm = 10'h000;
      3'h1: prescTerm = 10'h001;
      3'h2: prescTerm = 10'h003;
      3'h3: prescTerm = 10'h007;
      3'h4: prescTerm = 10'h00F;
      3'h5: prescTerm = 10'h03F;
      3'h6: prescTerm = 10'h0FF;
      3'h7: prescTerm = 10'h3FF;
    endcase
  end

  assign tick = s_q.enActive && !halt && (s_q.prescCnt == prescTerm);

  always_comb begin
    unique case (s_q.widthSel)
      TCC_W8:  widthMax = `TCC_MAX8;
      TCC_W32: widthMax = `TCC_MAX32;
      default: widthMax = `TCC_MAX16;
    endcase
  end

  assign isMatchMode = (s_q.waveMode == TCC_WM_MATCH_FREQUENCY_MODE) || (s_q.waveMode == TCC_WM_MATCH_PWM_MODE);
  assign isPwm       = (s_q.waveMode == TCC_WM_NORMAL_PWM_MODE) || (s_q.waveMode == TCC_WM_MATCH_PWM_MODE);

  always_comb begin
    if (isMatchMode) begin
      topVal = s_q.cmp0 & widthMax;
    end else if (s_q.widthSel == TCC_W8) begin
      topVal = {24'h000000, s_q.period};
    end else begin
      topVal = widthMax;
    end
  end

  always_comb begin
    readOk  = 1'b1;
    readSrc = s_q.snapshot;
    if ({3'h0, s_q.readAddr} == `TCC_IDX_COUNT) begin
      readSrc = s_q.count;
    end else if ({3'h0, s_q.readAddr} == `TCC_IDX_COMPARE0) begin
      readSrc = s_q.cmp0;
    end else if ({3'h0, s_q.readAddr} == `TCC_IDX_COMPARE1) begin
      readSrc = s_q.cmp1;
    end else begin
      readOk = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read views
  // ---------------------------------------------------------------
  assign mainCtrlRd = {2'h0, s_q.reloadSync, s_q.standbyRun, s_q.prescSel, 1'b0,
                       s_q.waveMode, 1'b0, s_q.widthSel, s_q.enable, s_q.swReset};
  assign ctrlbRd    = {s_q.cmd, 3'h0, s_q.singleRun, 1'b0, s_q.countDown};
  assign statusRd   = {s_q.swBusy | s_q.enBusy | s_q.rdBusy, 4'h0,
                       s_q.rdBusy, s_q.enBusy, s_q.swBusy};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        wrapEv;
    logic [31:0] cntNext;
    logic [1:0]  hit;
    wrapEv  = 1'b0;
    cntNext = s_q.count;
    hit     = 2'h0;
    s_d     = s_q;

    s_d.stbyMeta = standbyIn;
    s_d.stbySync = s_q.stbyMeta;

    // apb: answer one cycle after setup
    s_d.pready  = psel && !penable;
    s_d.pslverr = psel && !penable && !mapped;
    if (psel && !penable) begin
      s_d.prdata = `TCC_RST_WORD;
      if (!pwrite && mapped) begin
        unique case (regIdx)
          `TCC_IDX_MAIN_CONTROL:  s_d.prdata = {16'h0000, mainCtrlRd};
          `TCC_IDX_READ_SYNC_REQ: s_d.prdata = {16'h0000, 1'b0, s_q.contRead, 9'h000,
                                                s_q.readAddr};
          // both aliases show the same state
          `TCC_IDX_SECOND_CONTROL_CLEAR,
          `TCC_IDX_SECOND_CONTROL_SET:     s_d.prdata = {24'h000000, ctrlbRd};
          `TCC_IDX_SYNC_STATUS:   s_d.prdata = {24'h000000, statusRd};
          `TCC_IDX_COUNT:         s_d.prdata = s_q.snapshot;
          `TCC_IDX_PERIOD:        s_d.prdata = {24'h000000, s_q.period};
          `TCC_IDX_COMPARE0:      s_d.prdata = s_q.cmp0;
          `TCC_IDX_COMPARE1:      s_d.prdata = s_q.cmp1;
          default:                s_d.prdata = `TCC_RST_WORD;
        endcase
      end
    end

    // prescaler runs while enabled and not halted
    if (s_q.enActive && !halt) begin
      s_d.prescCnt = tick ? 10'h000 : s_q.prescCnt + 10'h001;
    end

    // counting, wrap and waveform on each tick while running
    if (tick && s_q.running) begin
      if (s_q.reloadPend) begin
        cntNext        = s_q.countDown ? topVal : `TCC_RST_WORD;
        s_d.reloadPend = 1'b0;
      end else if (!s_q.countDown) begin
        wrapEv  = (s_q.count >= topVal);
        cntNext = wrapEv ? `TCC_RST_WORD : s_q.count + 32'h0000_0001;
      end else begin
        wrapEv  = (s_q.count == `TCC_RST_WORD);
        cntNext = wrapEv ? topVal : s_q.count - 32'h0000_0001;
      end
      s_d.count = cntNext;
      hit[0] = (s_q.count == (s_q.cmp0 & widthMax));
      hit[1] = (s_q.count == (s_q.cmp1 & widthMax));
      for (int i = 0; i < 2; i++) begin
        if (!isPwm) begin
          if (hit[i]) begin
            s_d.wave[i] = !s_q.wave[i];
          end
        end else begin
          if (hit[i]) begin
            s_d.wave[i] = s_q.countDown;
          end else if (wrapEv) begin
            s_d.wave[i] = !s_q.countDown;
          end
        end
      end
      if (wrapEv && s_q.singleRun) begin
        s_d.running = 1'b0;
      end
      // prescaler reset on wrap in resync mode
      if (wrapEv && s_q.reloadSync == TCC_RS_RESYNC) begin
        s_d.prescCnt = 10'h000;
      end
    end

    // command executes on tick, then clears
    if (tick && s_q.cmd != TCC_CMD_NONE) begin
      s_d.cmd = TCC_CMD_NONE;
      unique case (s_q.cmd)
        TCC_CMD_RETRIG: begin
          s_d.running = 1'b1;
          unique case (s_q.reloadSync)
            TCC_RS_PRESCALE: s_d.reloadPend = 1'b1;
            TCC_RS_RESYNC: begin
              s_d.count    = s_q.countDown ? topVal : `TCC_RST_WORD;
              s_d.prescCnt = 10'h000;
            end
            default: s_d.count = s_q.countDown ? topVal : `TCC_RST_WORD;
          endcase
        end
        TCC_CMD_STOP: s_d.running = 1'b0;
        default:      s_d.cmd = TCC_CMD_NONE;
      endcase
    end

    // enable crossing completes after fixed sync delay
    if (s_q.enBusy || s_q.swBusy) begin
      s_d.ctrlCnt = s_q.ctrlCnt + 3'h1;
      if (s_q.ctrlCnt == `TCC_SYNC_LAST) begin
        s_d.enBusy   = 1'b0;
        s_d.enActive = s_q.enable;
        s_d.running  = s_q.enable;
        s_d.ctrlCnt  = 3'h0;
      end
    end

    if (s_q.contRead && !s_q.rdBusy && readOk && readSrc != s_q.snapshot) begin
      s_d.rdBusy = 1'b1;
      s_d.rdCnt  = 3'h0;
    end
    if (s_q.rdBusy) begin
      s_d.rdCnt = s_q.rdCnt + 3'h1;
      if (s_q.rdCnt == `TCC_SYNC_LAST) begin
        s_d.rdBusy = 1'b0;
        if (readOk) begin
          s_d.snapshot = readSrc;
        end
      end
    end

    // software writes take effect at the access edge
    if (wrAcc) begin
      unique case (regIdx)
        `TCC_IDX_MAIN_CONTROL: begin
          if (s_q.swBusy) begin
            s_d.swReset = 1'b1;
          end else if (pwdata[`TCC_MC_SOFTWARE_RESET]) begin
            s_d.swReset = 1'b1;
            s_d.swBusy  = 1'b1;
            s_d.enBusy  = 1'b0;
            s_d.ctrlCnt = 3'h0;
          end else begin
            s_d.enable  = pwdata[`TCC_MC_ENABLE];
            s_d.enBusy  = 1'b1;
            s_d.ctrlCnt = 3'h0;
            // config applies at once when disabled
            if (!s_q.enable) begin
              s_d.reloadSync = tcc_rsync_e'(pwdata[`TCC_MC_RSYNC_LO +: 2]);
              s_d.standbyRun = pwdata[`TCC_MC_STBY];
              s_d.prescSel   = pwdata[`TCC_MC_PRESC_LO +: 3];
              s_d.waveMode   = tcc_wave_e'(pwdata[`TCC_MC_WAVE_LO +: 2]);
              s_d.widthSel   = tcc_width_e'(pwdata[`TCC_MC_WIDTH_LO +: 2]);
            end
          end
        end
        `TCC_IDX_READ_SYNC_REQ: begin
          s_d.contRead = pwdata[`TCC_RR_CONT];
          s_d.readAddr = pwdata[4:0];
          if (pwdata[`TCC_RR_REQ]) begin
            s_d.rdBusy = 1'b1;
            s_d.rdCnt  = 3'h0;
          end
        end
        `TCC_IDX_SECOND_CONTROL_CLEAR: begin
          if (pwdata[`TCC_CB_CMD_LO +: 2] != 2'h0) begin
            s_d.cmd = TCC_CMD_NONE;
          end
          if (pwdata[`TCC_CB_SINGLE]) begin
            s_d.singleRun = 1'b0;
          end
          if (pwdata[`TCC_CB_DIR]) begin
            s_d.countDown = 1'b0;
          end
        end
        `TCC_IDX_SECOND_CONTROL_SET: begin
          if (pwdata[`TCC_CB_CMD_LO +: 2] != 2'h0) begin
            s_d.cmd = tcc_cmd_e'(pwdata[`TCC_CB_CMD_LO +: 2]);
          end
          if (pwdata[`TCC_CB_SINGLE]) begin
            s_d.singleRun = 1'b1;
          end
          if (pwdata[`TCC_CB_DIR]) begin
            s_d.countDown = 1'b1;
          end
        end
        `TCC_IDX_PERIOD:   s_d.period = pwdata[7:0];
        `TCC_IDX_COMPARE0: s_d.cmp0 = pwdata;
        `TCC_IDX_COMPARE1: s_d.cmp1 = pwdata;
        default:           s_d.period = s_q.period;
      endcase
    end

    // all state but the standby sync, pready and pslverr back to initial state (prdata to zero), timer disabled
    if (s_q.swBusy && s_q.ctrlCnt == `TCC_SYNC_LAST) begin
      s_d          = '0;
      s_d.stbyMeta = standbyIn;
      s_d.stbySync = s_q.stbyMeta;
      s_d.pready   = psel && !penable;
      s_d.pslverr  = psel && !penable && !mapped;
      s_d.prdata   = s_q.pready ? `TCC_RST_WORD : s_d.prdata;
      if (psel && !penable && !pwrite && mapped) begin
        s_d.prdata = `TCC_RST_WORD;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready       = s_q.pready;
  assign prdata       = s_q.prdata;
  assign pslverr      = s_q.pslverr;
  assign waveOut      = s_q.wave;
  assign countRunning = s_q.running;

endmodule : tcc_top

/* File: tcc_top_chk.sv */
// protocol and behaviour checker for the timer control block ports
module tcc_top_chk
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // system and timer
  input wire logic        standbyIn,
  input wire logic [1:0]  waveOut,
  input wire logic        countRunning
);
  logic mapIdx;
  assign mapIdx = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                  (paddr[9:2] inside {8'h00, 8'h02, 8'h04, 8'h05, 8'h0F, 8'h10, 8'h14,
                                      8'h18, 8'h1C});

  setup_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    psel && !penable |=> pready) else $error("no answer after setup");
  ready_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    pready |-> psel && penable && $past(psel && !penable)) else $error("stray pready");
  ready_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    pready |=> !pready) else $error("pready longer than one cycle");
  err_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error response");
  err_unmapped_a: assert property (@(posedge clk) disable iff (!rst_n)
    psel && !penable && !mapIdx |=> pslverr) else $error("unmapped not refused");
  ok_mapped_a: assert property (@(posedge clk) disable iff (!rst_n)
    psel && !penable && mapIdx |=> !pslverr) else $error("mapped refused");
  req_reads_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    pready && !pwrite && paddr[9:2] == 8'h02 |-> !prdata[15]) else $error("request bit read 1");
  software_reset_stops_a: assert property (@(posedge clk) disable iff (!rst_n)
    pready && pwrite && paddr[9:2] == 8'h00 && pwdata[0] |-> ##[1:6] !countRunning)
    else $error("timer still running after soft reset");
  reset_quiet_a: assert property (@(posedge clk)
    !rst_n |=> !pready && !pslverr && waveOut == 2'b00 && !countRunning)
    else $error("outputs active after reset");
endmodule : tcc_top_chk

bind tcc_top tcc_top_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .standbyIn(standbyIn), .waveOut(waveOut), .countRunning(countRunning));

/* File: tcc_top_tb.sv */
// self-checking testbench of the timer control block
module tcc_top_tb
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        standbyIn = 1'b0;
  logic [1:0]  waveOut;
  logic        countRunning;
  int          nErrors = 0;
  int          numChecks = 0;
  int          cyc = 0;
  logic [31:0] r;
  logic        e;

  tcc_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .standbyIn(standbyIn), .waveOut(waveOut), .countRunning(countRunning));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] rv, output logic ev);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask : rdc

  // polls the status register until bit b clears
  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h0F, 32'h0000_0000, r, e);
      k++;
    end while (r[b] !== 1'b0 && k < 20);
    chk({31'h0, r[b]}, 32'h0000_0000);
  endtask : poll

  task automatic waitRun(input logic v, input int lim);
    int k;
    k = 0;
    while (countRunning !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, countRunning}, {31'h0, v});
  endtask : waitRun

  task report_and_stop;
    $display("checks=%0d mismatches=%0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      nErrors++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h02, 32'h0000_0000);
    rdc(8'h04, 32'h0000_0000);
    rdc(8'h05, 32'h0000_0000);
    rdc(8'h0F, 32'h0000_0000);
    rdc(8'h10, 32'h0000_0000);
    rdc(8'h14, 32'h0000_0000);
    rdc(8'h18, 32'h0000_0000);
    rdc(8'h1C, 32'h0000_0000);
    apb(1'b0, 8'h03, 32'h0000_0000, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    $display("reset values done");
    wr(8'h00, 32'h0000_2F68);
    rdc(8'h00, 32'h0000_2F68);
    wr(8'h00, 32'h0000_2F6A);
    rdc(8'h0F, 32'h0000_0082);
    rdc(8'h00, 32'h0000_2F6A);
    poll(1);
    wr(8'h00, 32'h0000_0000);
    rdc(8'h00, 32'h0000_2F68);
    poll(1);
    $display("enable done");
    wr(8'h14, 32'h0000_0022);
    wr(8'h05, 32'h0000_0004);
    wr(8'h00, 32'h0000_2F6B);
    apb(1'b0, 8'h0F, 32'h0000_0000, r, e);
    chk(r & 32'h0000_0081, 32'h0000_0081);
    poll(0);
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h14, 32'h0000_0000);
    rdc(8'h05, 32'h0000_0000);
    wr(8'h00, 32'h0000_2F6B);
    rdc(8'h00, 32'h0000_0001);
    poll(0);
    $display("soft reset done");
    wr(8'h18, 32'h1234_5678);
    wr(8'h02, 32'h0000_8018);
    rdc(8'h02, 32'h0000_0018);
    poll(2);
    rdc(8'h10, 32'h1234_5678);
    wr(8'h02, 32'h0000_8014);
    poll(2);
    rdc(8'h10, 32'h1234_5678);
    wr(8'h02, 32'h0000_4018);
    wr(8'h18, 32'hA5A5_0001);
    repeat (10) @(posedge clk);
    rdc(8'h10, 32'hA5A5_0001);
    $display("read sync done");
    wr(8'h14, 32'h0000_0008);
    wr(8'h00, 32'h0000_0046);
    poll(1);
    wr(8'h05, 32'h0000_0044);
    waitRun(1'b1, 20);
    rdc(8'h05, 32'h0000_0004);
    waitRun(1'b0, 100);
    chk({30'h0, waveOut}, 32'h0000_0003);
    rdc(8'h04, 32'h0000_0004);
    wr(8'h04, 32'h0000_0004);
    rdc(8'h05, 32'h0000_0000);
    wr(8'h05, 32'h0000_0040);
    waitRun(1'b1, 20);
    repeat (40) @(posedge clk);
    chk({31'h0, countRunning}, 32'h0000_0001);
    standbyIn <= 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h05, 32'h0000_0080);
    repeat (20) @(posedge clk);
    rdc(8'h05, 32'h0000_0080);
    chk({31'h0, countRunning}, 32'h0000_0001);
    standbyIn <= 1'b0;
    waitRun(1'b0, 20);
    $display("commands done");
    wr(8'h00, 32'h0000_0004);
    poll(1);
    wr(8'h00, 32'h0000_0706);
    poll(1);
    wr(8'h05, 32'h0000_0080);
    wr(8'h04, 32'h0000_00C0);
    rdc(8'h05, 32'h0000_0000);
    repeat (1100) @(posedge clk);
    chk({31'h0, countRunning}, 32'h0000_0001);
    wr(8'h00, 32'h0000_0001);
    waitRun(1'b0, 10);
    $display("cancel done");
    report_and_stop();
  end
endmodule : tcc_top_tb
